// >>> core/ass_params.svh
// constants for the addressing-space block: map, register offsets, stack figures
// assumes inclusion by bare name from the package and the design file
`ifndef ASS_PARAMS_SVH
`define ASS_PARAMS_SVH
`define ASS_RESET_VEC_LO 16'h0000
`define ASS_RESET_VEC_HI 16'h0002
`define ASS_IRQ_VEC_LO 16'h0003
`define ASS_IRQ_VEC_HI 16'h0020
`define ASS_MBF_LAST 16'h03ff
`define ASS_OPT_LO 16'h3000
`define ASS_OPT_HI 16'h307f
`define ASS_OPT_USED_HI 16'h3007
`define ASS_RAM_PAGE 8'h20
`define ASS_SSP_RESET 8'hff
`define ASS_USER_STACK_TOP_RESET 8'h00
`define ASS_STEP_SYS 8'h02
`define ASS_STEP_USR 8'h01
`define ASS_CFG_USER_STACK_TOP_PAGE 8'h05
`define ASS_CFG_USER_STACK_TOP_LOC 8'h06
`define ASS_CFG_SSP_PAGE 8'h2c
`define ASS_CFG_SSP_LOC 8'h2d
`define ASS_IN_USP_PAGE 8'h0b
`define ASS_IN_USP_LOC 8'h0c
`define ASS_ZERO8 8'h00
`define ASS_ONE16 16'h0001
`endif

// >>> core/ass_pkg.sv
// types for the addressing-space block
// assumes the params header is on the include path
`include "ass_params.svh"
package ass_pkg;
   typedef enum logic [3:0] {
      ASS_OP_NONE,
      ASS_OP_REG_MOVE,
      ASS_OP_REG_WRITE,
      ASS_OP_CALL,
      ASS_OP_RETURN,
      ASS_OP_USER_PUSH,
      ASS_OP_USER_POP,
      ASS_OP_INPUT_LOAD,
      ASS_OP_OUT_IMM,
      ASS_OP_OUT_REG,
      ASS_OP_OUT_MEM_DIR,
      ASS_OP_OUT_MEM_IND,
      ASS_OP_CFG_WRITE,
      ASS_OP_CFG_READ
   } ass_op_t;

   typedef enum logic [2:0] {
      ASS_REG_RESET_VEC,
      ASS_REG_IRQ_VEC,
      ASS_REG_MBF_PROG,
      ASS_REG_PROG,
      ASS_REG_OPTION,
      ASS_REG_RAM,
      ASS_REG_UNMAPPED
   } ass_region_t;
endpackage : ass_pkg

// >>> core/ass_core.sv
// addressing-space core: register array, stacks, input/output/config bank access
// assumes the execution unit issues one op per cycle and waits for op_done_q;
// program/data memory and peripheral input bytes sit outside
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "ass_params.svh"
module ass_core #(
   parameter int NVM_LAST = 16'h1fff,
   parameter int FLAG_DEPTH = 16,
   parameter int FLAG_W = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire ass_pkg::ass_op_t op_code,
   input wire logic op_valid,
   input wire logic [7:0] op_dst,
   input wire logic [7:0] op_src,
   input wire logic [7:0] op_imm,
   input wire logic [15:0] op_pc,
   input wire logic op_is_irq,
   input wire logic [FLAG_W-1:0] op_flags,
   input wire logic [7:0] in_bank_data,
   input wire logic [7:0] mem_rdata,
   input wire logic [15:0] fetch_addr,
   output logic op_done_q,
   output logic [15:0] pc_restore_q,
   output logic pc_restore_valid_q,
   output logic [FLAG_W-1:0] flags_restore_q,
   output logic [7:0] in_bank_sel_q,
   output logic [7:0] out_addr_q,
   output logic [7:0] out_data_q,
   output logic out_we_q,
   output logic [15:0] mem_addr_q,
   output logic [7:0] mem_wdata_q,
   output logic mem_we_q,
   output logic [7:0] cfg_rdata_q,
   output ass_pkg::ass_region_t region_q,
   output logic [7:0] rd_data_q
);
   import ass_pkg::*;

   localparam int FD_W = $clog2(FLAG_DEPTH + 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ASS_ST_IDLE, ASS_ST_STEP2, ASS_ST_MEMWAIT} ass_step_t;

   typedef struct packed {
      logic [255:0][7:0] regs;
      logic [7:0] ssp_loc;
      logic [7:0] user_stack_top_page;
      logic [7:0] user_stack_top_loc;
      logic [7:0] usp_loc;
      logic [FLAG_DEPTH-1:0][FLAG_W-1:0] fstack;
      logic [FD_W-1:0] fdepth;
      ass_step_t step;
      ass_op_t op;
      logic [7:0] dst;
      logic [7:0] hold;
      logic was_irq;
      logic done;
      logic [15:0] pc_rest;
      logic pc_rest_v;
      logic [FLAG_W-1:0] flags_rest;
      logic [7:0] in_sel;
      logic [7:0] out_addr;
      logic [7:0] out_data;
      logic out_we;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
      logic mem_we;
      logic [7:0] cfg_rdata;
      ass_region_t region;
      logic [7:0] rd_data;
   } ass_state_t;

   ass_state_t s_q;
   ass_state_t s_d;

   // map a program/data address onto its region
   function automatic ass_region_t ass_decode(input logic [15:0] a);
      ass_region_t r;
      r = ASS_REG_UNMAPPED;
      if (a <= `ASS_RESET_VEC_HI) begin
         r = ASS_REG_RESET_VEC;
      end else if (a <= `ASS_IRQ_VEC_HI) begin
         r = ASS_REG_IRQ_VEC;
      end else if (a <= `ASS_MBF_LAST) begin
         r = ASS_REG_MBF_PROG;
      end else if (a <= 16'(NVM_LAST)) begin
         r = ASS_REG_PROG;
      end else if (a >= `ASS_OPT_LO && a <= `ASS_OPT_HI) begin
         r = ASS_REG_OPTION;
      end else if (a[15:8] == `ASS_RAM_PAGE) begin
         r = ASS_REG_RAM;
      end
      return r;
   endfunction : ass_decode

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.pc_rest_v = 1'b0;
      s_d.out_we = 1'b0;
      s_d.mem_we = 1'b0;
      s_d.region = ass_decode(fetch_addr);
      unique case (s_q.step)
         ASS_ST_IDLE: begin
            if (op_valid) begin
               s_d.op = op_code;
               s_d.dst = op_dst;
               unique case (op_code)
                  ASS_OP_NONE: begin
                     s_d.done = 1'b1;
                  end
                  ASS_OP_REG_MOVE: begin
                     s_d.regs[op_dst] = s_q.regs[op_src];
                     s_d.done = 1'b1;
                  end
                  ASS_OP_REG_WRITE: begin
                     s_d.regs[op_dst] = op_imm;
                     s_d.rd_data = s_q.regs[op_src];
                     s_d.done = 1'b1;
                  end
                  ASS_OP_CALL: begin
                     // low byte at the pointer, high byte just below it
                     s_d.mem_addr = {`ASS_RAM_PAGE, s_q.ssp_loc};
                     s_d.mem_wdata = op_pc[7:0];
                     s_d.mem_we = 1'b1;
                     s_d.hold = op_pc[15:8];
                     s_d.was_irq = op_is_irq;
                     if (op_is_irq && s_q.fdepth < FD_W'(FLAG_DEPTH)) begin
                        s_d.fstack[s_q.fdepth] = op_flags;
                        s_d.fdepth = s_q.fdepth + FD_W'(1);
                     end
                     s_d.step = ASS_ST_STEP2;
                  end
                  ASS_OP_RETURN: begin
                     s_d.ssp_loc = s_q.ssp_loc + `ASS_STEP_SYS;
                     s_d.hold = `ASS_ZERO8;
                     s_d.mem_addr = {`ASS_RAM_PAGE, s_q.ssp_loc + `ASS_STEP_SYS};
                     s_d.was_irq = op_is_irq;
                     s_d.step = ASS_ST_MEMWAIT;
                  end
                  ASS_OP_USER_PUSH: begin
                     s_d.mem_addr = {`ASS_RAM_PAGE, s_q.usp_loc};
                     s_d.mem_wdata = s_q.regs[op_src];
                     s_d.mem_we = 1'b1;
                     s_d.usp_loc = s_q.usp_loc + `ASS_STEP_USR;
                     s_d.done = 1'b1;
                  end
                  ASS_OP_USER_POP: begin
                     s_d.usp_loc = s_q.usp_loc - `ASS_STEP_USR;
                     s_d.mem_addr = {`ASS_RAM_PAGE, s_q.usp_loc - `ASS_STEP_USR};
                     s_d.step = ASS_ST_MEMWAIT;
                  end
                  ASS_OP_INPUT_LOAD: begin
                     s_d.in_sel = op_src;
                     s_d.step = ASS_ST_STEP2;
                  end
                  ASS_OP_OUT_IMM: begin
                     s_d.out_addr = op_dst;
                     s_d.out_data = op_imm;
                     s_d.out_we = 1'b1;
                     s_d.done = 1'b1;
                  end
                  ASS_OP_OUT_REG: begin
                     s_d.out_addr = op_dst;
                     s_d.out_data = s_q.regs[op_src];
                     s_d.out_we = 1'b1;
                     s_d.done = 1'b1;
                  end
                  ASS_OP_OUT_MEM_DIR: begin
                     s_d.mem_addr = {op_imm, op_src};
                     s_d.step = ASS_ST_MEMWAIT;
                  end
                  ASS_OP_OUT_MEM_IND: begin
                     // pointer is a register pair: src holds low, src+1 high
                     s_d.mem_addr = {s_q.regs[op_src + 8'h01], s_q.regs[op_src]};
                     s_d.step = ASS_ST_MEMWAIT;
                  end
                  ASS_OP_CFG_WRITE: begin
                     unique case (op_dst)
                        `ASS_CFG_SSP_LOC: s_d.ssp_loc = op_imm;
                        `ASS_CFG_USER_STACK_TOP_PAGE: begin
                           s_d.user_stack_top_page = op_imm;
                           s_d.usp_loc = s_q.user_stack_top_loc;
                        end
                        `ASS_CFG_USER_STACK_TOP_LOC: begin
                           s_d.user_stack_top_loc = op_imm;
                           s_d.usp_loc = op_imm;
                        end
                        default: ; // page byte of the system pointer is fixed
                     endcase
                     s_d.done = 1'b1;
                  end
                  ASS_OP_CFG_READ: begin
                     unique case (op_src)
                        `ASS_CFG_SSP_PAGE: s_d.cfg_rdata = `ASS_RAM_PAGE;
                        `ASS_CFG_SSP_LOC: s_d.cfg_rdata = s_q.ssp_loc;
                        `ASS_CFG_USER_STACK_TOP_PAGE: s_d.cfg_rdata = s_q.user_stack_top_page;
                        `ASS_CFG_USER_STACK_TOP_LOC: s_d.cfg_rdata = s_q.user_stack_top_loc;
                        default: s_d.cfg_rdata = `ASS_ZERO8;
                     endcase
                     s_d.done = 1'b1;
                  end
                  default: s_d.done = 1'b1;
               endcase
            end
         end
         ASS_ST_STEP2: begin
            if (s_q.op == ASS_OP_CALL) begin
               s_d.mem_addr = {`ASS_RAM_PAGE, s_q.ssp_loc - 8'h01};
               s_d.mem_wdata = s_q.hold;
               s_d.mem_we = 1'b1;
               s_d.ssp_loc = s_q.ssp_loc - `ASS_STEP_SYS;
            end else begin
               // user stack pointer is internal, so served here, not by the bank
               if (s_q.in_sel == `ASS_IN_USP_PAGE) begin
                  s_d.regs[s_q.dst] = `ASS_RAM_PAGE;
               end else if (s_q.in_sel == `ASS_IN_USP_LOC) begin
                  s_d.regs[s_q.dst] = s_q.usp_loc;
               end else begin
                  s_d.regs[s_q.dst] = in_bank_data;
               end
            end
            s_d.done = 1'b1;
            s_d.step = ASS_ST_IDLE;
         end
         ASS_ST_MEMWAIT: begin
            // memory answers one cycle after the address
            unique case (s_q.op)
               ASS_OP_RETURN: begin
                  if (s_q.hold == `ASS_ZERO8 && s_q.mem_addr[0] == s_q.ssp_loc[0]) begin
                     s_d.pc_rest[7:0] = mem_rdata;
                     s_d.mem_addr = s_q.mem_addr - `ASS_ONE16;
                     s_d.hold = 8'h01;
                  end else begin
                     s_d.pc_rest[15:8] = mem_rdata;
                     s_d.pc_rest_v = 1'b1;
                     s_d.hold = `ASS_ZERO8;
                     if (s_q.was_irq && s_q.fdepth != '0) begin
                        s_d.flags_rest = s_q.fstack[s_q.fdepth - FD_W'(1)];
                        s_d.fdepth = s_q.fdepth - FD_W'(1);
                     end
                     s_d.done = 1'b1;
                     s_d.step = ASS_ST_IDLE;
                  end
               end
               ASS_OP_USER_POP: begin
                  s_d.regs[s_q.dst] = mem_rdata;
                  s_d.done = 1'b1;
                  s_d.step = ASS_ST_IDLE;
               end
               default: begin
                  s_d.out_addr = s_q.dst;
                  s_d.out_data = mem_rdata;
                  s_d.out_we = 1'b1;
                  s_d.done = 1'b1;
                  s_d.step = ASS_ST_IDLE;
               end
            endcase
         end
         default: s_d.step = ASS_ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.ssp_loc <= `ASS_SSP_RESET;
         s_q.user_stack_top_page <= `ASS_RAM_PAGE;
         s_q.user_stack_top_loc <= `ASS_USER_STACK_TOP_RESET;
         s_q.usp_loc <= `ASS_USER_STACK_TOP_RESET;
         s_q.step <= ASS_ST_IDLE;
         s_q.op <= ASS_OP_NONE;
         s_q.region <= ASS_REG_RESET_VEC;
      end else begin
         s_q <= s_d;
      end
   end

   assign op_done_q = s_q.done;
   assign pc_restore_q = s_q.pc_rest;
   assign pc_restore_valid_q = s_q.pc_rest_v;
   assign flags_restore_q = s_q.flags_rest;
   assign in_bank_sel_q = s_q.in_sel;
   assign out_addr_q = s_q.out_addr;
   assign out_data_q = s_q.out_data;
   assign out_we_q = s_q.out_we;
   assign mem_addr_q = s_q.mem_addr;
   assign mem_wdata_q = s_q.mem_wdata;
   assign mem_we_q = s_q.mem_we;
   assign cfg_rdata_q = s_q.cfg_rdata;
   assign region_q = s_q.region;
   assign rd_data_q = s_q.rd_data;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_call_issue;
      op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_CALL;
   endsequence

   property p_call_drop;
      @(posedge core_clk) disable iff (sys_rst)
      s_call_issue |=> ##1 (s_q.ssp_loc == $past(s_q.ssp_loc, 2) - 8'h02);
   endproperty
   a_call_drop: assert property (p_call_drop) else $error("call pointer step wrong");

   property p_call_write;
      @(posedge core_clk) disable iff (sys_rst)
      s_call_issue |=> mem_we_q && mem_addr_q[15:8] == 8'h20 ##1 mem_we_q;
   endproperty
   a_call_write: assert property (p_call_write) else $error("call store missing");

   property p_ret_rise;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_RETURN)
         |=> s_q.ssp_loc == $past(s_q.ssp_loc) + 8'h02 ##[1:3] pc_restore_valid_q;
   endproperty
   a_ret_rise: assert property (p_ret_rise) else $error("return pointer wrong");

   property p_push_inc;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_USER_PUSH)
         |=> s_q.usp_loc == $past(s_q.usp_loc) + 8'h01 && mem_we_q
             && mem_wdata_q == $past(s_q.regs[op_src]);
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("user push wrong");

   property p_pop_dec;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_USER_POP)
         |=> s_q.usp_loc == $past(s_q.usp_loc) - 8'h01 ##1 op_done_q;
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("user pop wrong");

   property p_user_stack_top_load;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_CFG_WRITE
         && op_dst == 8'h06) |=> s_q.usp_loc == $past(op_imm);
   endproperty
   a_user_stack_top_load: assert property (p_user_stack_top_load) else $error("user top not copied");

   property p_ssp_page;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_CFG_READ
         && op_src == 8'h2c) |=> cfg_rdata_q == 8'h20;
   endproperty
   a_ssp_page: assert property (p_ssp_page) else $error("system page not 20h");

   property p_move;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_REG_MOVE)
         |=> s_q.regs[$past(op_dst)] == $past(s_q.regs[op_src]);
   endproperty
   a_move: assert property (p_move) else $error("move not copied");

   property p_out_imm;
      @(posedge core_clk) disable iff (sys_rst)
      (op_valid && s_q.step == ASS_ST_IDLE && op_code == ASS_OP_OUT_IMM)
         |=> out_we_q && out_data_q == $past(op_imm) ##1 !out_we_q;
   endproperty
   a_out_imm: assert property (p_out_imm) else $error("output write wrong");
endmodule : ass_core

// >>> bench/ass_mem_model.sv
// behavioural program/data memory and peripheral input bank beside the addressing core
// assumes one clock; read data follows the address at once, writes land on the edge
`timescale 1ns/1ps
module ass_mem_model (
   input wire logic core_clk,
   input wire logic [15:0] mem_addr_q,
   input wire logic [7:0] mem_wdata_q,
   input wire logic mem_we_q,
   input wire logic [7:0] in_bank_sel_q,
   output logic [7:0] mem_rdata,
   output logic [7:0] in_bank_data
);
   // ----------------------------------------------------------------
   // storage, preset to an address-dependent pattern
   // ----------------------------------------------------------------
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
      end
   end
   // the core samples the byte at the edge after it registers the address
   always @(posedge core_clk) begin
      if (mem_we_q === 1'b1) begin
         mem[mem_addr_q] <= mem_wdata_q;
      end
   end
   assign mem_rdata = mem[mem_addr_q];
   // each input byte carries its selector, so a wrong selector is seen
   assign in_bank_data = in_bank_sel_q ^ 8'hc3;
endmodule : ass_mem_model

// >>> bench/ass_core_tb.sv
// self-checking bench for the addressing-space core, driven op by op
// assumes the memory model answers reads at once from the registered address, the core sampling one edge later
`timescale 1ns/1ps
module ass_core_tb;
   import ass_pkg::*;
   logic core_clk, sys_rst, op_valid, op_is_irq, op_done_q, pc_restore_valid_q;
   logic out_we_q, mem_we_q;
   ass_op_t op_code;
   ass_region_t region_q;
   logic [7:0] op_dst, op_src, op_imm, in_bank_data, mem_rdata, in_bank_sel_q;
   logic [7:0] out_addr_q, out_data_q, mem_wdata_q, cfg_rdata_q, rd_data_q;
   logic [15:0] op_pc, fetch_addr, pc_restore_q, mem_addr_q, out_seen, pc_seen;
   logic [3:0] op_flags, flags_restore_q;
   int fails = 0;
   int comparisons = 0;
   localparam logic [15:0] RA[14] = '{16'h0000, 16'h0002, 16'h0003, 16'h0020, 16'h0021,
      16'h03ff, 16'h0400, 16'h1fff, 16'h2000, 16'h20ff, 16'h3000, 16'h307f, 16'h3080, 16'h2100};
   localparam ass_region_t RE[14] = '{ASS_REG_RESET_VEC, ASS_REG_RESET_VEC, ASS_REG_IRQ_VEC,
      ASS_REG_IRQ_VEC, ASS_REG_MBF_PROG, ASS_REG_MBF_PROG, ASS_REG_PROG, ASS_REG_PROG,
      ASS_REG_RAM, ASS_REG_RAM, ASS_REG_OPTION, ASS_REG_OPTION, ASS_REG_UNMAPPED,
      ASS_REG_UNMAPPED};
   localparam logic [7:0] RR[4] = '{8'h00, 8'h01, 8'h7f, 8'hff};

   ass_core ass_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .op_code(op_code),
      .op_valid(op_valid), .op_dst(op_dst), .op_src(op_src), .op_imm(op_imm), .op_pc(op_pc),
      .op_is_irq(op_is_irq), .op_flags(op_flags), .in_bank_data(in_bank_data),
      .mem_rdata(mem_rdata), .fetch_addr(fetch_addr), .op_done_q(op_done_q),
      .pc_restore_q(pc_restore_q), .pc_restore_valid_q(pc_restore_valid_q),
      .flags_restore_q(flags_restore_q), .in_bank_sel_q(in_bank_sel_q),
      .out_addr_q(out_addr_q), .out_data_q(out_data_q), .out_we_q(out_we_q),
      .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q),
      .cfg_rdata_q(cfg_rdata_q), .region_q(region_q), .rd_data_q(rd_data_q));
   ass_mem_model ass_mem_model_i (.core_clk(core_clk), .mem_addr_q(mem_addr_q),
      .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .in_bank_sel_q(in_bank_sel_q),
      .mem_rdata(mem_rdata), .in_bank_data(in_bank_data));

   // ----------------------------------------------------------------
   // clock, pulse capture, watchdog
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // pulses stand one cycle, so they are latched here for the tests
   always @(posedge core_clk) begin
      #1;
      if (out_we_q === 1'b1)
         out_seen = {out_addr_q, out_data_q};
      if (pc_restore_valid_q === 1'b1)
         pc_seen = pc_restore_q;
   end
   initial begin
      repeat (4000) @(posedge core_clk);
      fails++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction : pat
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic do_op(input ass_op_t c, input logic [7:0] d, input logic [7:0] s,
         input logic [7:0] i, input logic [15:0] pc = 16'h0000, input logic irq = 1'b0,
         input logic [3:0] fl = 4'h0);
      int n;
      @(negedge core_clk);
      op_code = c;
      op_dst = d;
      op_src = s;
      op_imm = i;
      op_pc = pc;
      op_is_irq = irq;
      op_flags = fl;
      op_valid = 1'b1;
      @(negedge core_clk);
      op_valid = 1'b0;
      n = 0;
      while (op_done_q !== 1'b1 && n < 8) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(16'(op_done_q), 16'h0001);
      // one more edge so memory writes and the pulse latches have settled
      @(posedge core_clk);
      #1;
   endtask : do_op
   task automatic rd_reg(input logic [7:0] r, input logic [7:0] exp);
      out_seen = 16'hxxxx;
      do_op(ASS_OP_OUT_REG, 8'h00, r, 8'h00);
      check(out_seen, {8'h00, exp});
   endtask : rd_reg
   task automatic rd_cfg(input logic [7:0] a, input logic [7:0] exp);
      do_op(ASS_OP_CFG_READ, a, a, 8'h00);
      check(16'(cfg_rdata_q), 16'(exp));
   endtask : rd_cfg
   task automatic wr_cfg(input logic [7:0] a, input logic [7:0] v);
      do_op(ASS_OP_CFG_WRITE, a, a, v);
   endtask : wr_cfg
   task automatic stop_test();
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      op_valid = 1'b0;
      op_code = ASS_OP_NONE;
      {op_dst, op_src, op_imm, op_pc, op_is_irq, op_flags} = '0;
      fetch_addr = 16'h0000;
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      check(16'(region_q), 16'(ASS_REG_RESET_VEC));
      rd_cfg(8'h2c, 8'h20);
      rd_cfg(8'h2d, 8'hff);
      wr_cfg(8'h2d, 8'h41);
      rd_cfg(8'h2d, 8'h41);
      wr_cfg(8'h2c, 8'h55);
      rd_cfg(8'h2c, 8'h20);
      wr_cfg(8'h2d, 8'hff);
      foreach (RR[k]) do_op(ASS_OP_REG_WRITE, RR[k], RR[k], RR[k] ^ 8'ha5);
      do_op(ASS_OP_REG_MOVE, 8'h80, 8'hff, 8'h00);
      foreach (RR[k]) rd_reg(RR[k], RR[k] ^ 8'ha5);
      rd_reg(8'h80, 8'h5a);
      do_op(ASS_OP_REG_WRITE, 8'h12, 8'h80, 8'h00);
      check(16'(rd_data_q), 16'h005a);
      out_seen = 16'hxxxx;
      do_op(ASS_OP_OUT_IMM, 8'h17, 8'h00, 8'h9c);
      check(out_seen, 16'h179c);
      do_op(ASS_OP_OUT_MEM_DIR, 8'h05, 8'h34, 8'h12);
      check(out_seen, {8'h05, pat(16'h1234)});
      do_op(ASS_OP_REG_WRITE, 8'h10, 8'h10, 8'h78);
      do_op(ASS_OP_REG_WRITE, 8'h11, 8'h11, 8'h05);
      do_op(ASS_OP_OUT_MEM_IND, 8'h06, 8'h10, 8'h00);
      check(out_seen, {8'h06, pat(16'h0578)});
      do_op(ASS_OP_INPUT_LOAD, 8'h20, 8'h16, 8'h00);
      check(16'(in_bank_sel_q), 16'h0016);
      rd_reg(8'h20, 8'h16 ^ 8'hc3);
      do_op(ASS_OP_CALL, 8'h00, 8'h00, 8'h00, 16'habcd, 1'b1, 4'ha);
      check({ass_mem_model_i.mem[16'h20fe], ass_mem_model_i.mem[16'h20ff]}, 16'habcd);
      rd_cfg(8'h2d, 8'hfd);
      do_op(ASS_OP_CALL, 8'h00, 8'h00, 8'h00, 16'h1357, 1'b1, 4'h5);
      check({ass_mem_model_i.mem[16'h20fc], ass_mem_model_i.mem[16'h20fd]}, 16'h1357);
      do_op(ASS_OP_RETURN, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b1);
      check(pc_seen, 16'h1357);
      check(16'(flags_restore_q), 16'h0005);
      rd_cfg(8'h2d, 8'hfd);
      do_op(ASS_OP_RETURN, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b1);
      check(pc_seen, 16'habcd);
      check(16'(flags_restore_q), 16'h000a);
      wr_cfg(8'h2d, 8'h01);
      do_op(ASS_OP_CALL, 8'h00, 8'h00, 8'h00, 16'h2468);
      check({ass_mem_model_i.mem[16'h2000], ass_mem_model_i.mem[16'h2001]}, 16'h2468);
      rd_cfg(8'h2d, 8'hff);
      do_op(ASS_OP_RETURN, 8'h00, 8'h00, 8'h00);
      check(pc_seen, 16'h2468);
      rd_cfg(8'h2d, 8'h01);
      wr_cfg(8'h2d, 8'hff);
      // user stack low in the page, system stack at the top, well apart
      wr_cfg(8'h05, 8'hff);
      wr_cfg(8'h06, 8'h40);
      do_op(ASS_OP_INPUT_LOAD, 8'h30, 8'h0c, 8'h00);
      do_op(ASS_OP_INPUT_LOAD, 8'h31, 8'h0b, 8'h00);
      rd_reg(8'h30, 8'h40);
      rd_reg(8'h31, 8'h20);
      do_op(ASS_OP_REG_WRITE, 8'h50, 8'h50, 8'he1);
      do_op(ASS_OP_USER_PUSH, 8'h00, 8'h50, 8'h00);
      do_op(ASS_OP_USER_PUSH, 8'h00, 8'h01, 8'h00);
      check({ass_mem_model_i.mem[16'h2040], ass_mem_model_i.mem[16'h2041]}, 16'he1a4);
      do_op(ASS_OP_INPUT_LOAD, 8'h30, 8'h0c, 8'h00);
      rd_reg(8'h30, 8'h42);
      do_op(ASS_OP_USER_POP, 8'h60, 8'h00, 8'h00);
      do_op(ASS_OP_USER_POP, 8'h61, 8'h00, 8'h00);
      rd_reg(8'h60, 8'ha4);
      rd_reg(8'h61, 8'he1);
      do_op(ASS_OP_INPUT_LOAD, 8'h30, 8'h0c, 8'h00);
      rd_reg(8'h30, 8'h40);
      foreach (RA[k]) begin
         @(negedge core_clk);
         fetch_addr = RA[k];
         @(posedge core_clk);
         #1;
         check(16'(region_q), 16'(RE[k]));
      end
      stop_test();
   end
endmodule : ass_core_tb
